// ==== stc_pkg.sv ====
// constants for the supervisor timer compare block
package stc_pkg;
    // csr numbers
    localparam logic [11:0] CSR_SUP_CMP = 12'h14d;
    localparam logic [11:0] CSR_SUP_CMP_UPPER = 12'h15d;
    localparam logic [11:0] CSR_GUEST_CMP = 12'h24d;
    localparam logic [11:0] CSR_GUEST_CMP_UPPER = 12'h25d;
    // feature enable position in env config (full and upper half)
    localparam int ENV_FEATURE_BIT = 63;
    localparam int ENV_FEATURE_BIT_UPPER = 31;
    // compare reset value: all ones keeps pending low after reset
    localparam logic [63:0] CMP_RESET = 64'hffff_ffff_ffff_ffff;
    // privilege encodings
    localparam logic [1:0] PRIV_U = 2'h0;
    localparam logic [1:0] PRIV_S = 2'h1;
    localparam logic [1:0] PRIV_M = 2'h3;
    // access verdicts
    typedef enum logic [1:0] {
        ACC_OK = 2'b00,
        ACC_ILLEGAL = 2'b01,
        ACC_VIRTUAL = 2'b10,
        ACC_NONE = 2'b11
    } access_t;
endpackage : stc_pkg

// ==== stc_compare.sv ====
// registered unsigned 64-bit greater-or-equal comparator
`timescale 1ns/1ps
module stc_compare #(
    parameter int WIDTH = 64
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // operands
    input wire logic [WIDTH-1:0] value_i,
    input wire logic [WIDTH-1:0] limit_i,
    // result
    output logic reached_o
);
    initial begin
        if (WIDTH < 2) begin
            $error("stc_compare: WIDTH too small");
        end
    end

    logic [WIDTH-1:0] value_q;
    logic [WIDTH-1:0] limit_q;

    // stage operands, then compare
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            value_q <= '0;
            limit_q <= '1;
        end else begin
            value_q <= value_i;
            limit_q <= limit_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            reached_o <= 1'b0;
        end else begin
            reached_o <= (value_q >= limit_q);
        end
    end
endmodule : stc_compare

// ==== supervisor_timer_compare.sv ====
// supervisor and guest timer compare csrs, pending bits, access gating
// What this block does
// - supervisor compare holds 64 bits with full precision on both bases
// - on 32-bit base main address reaches low half, upper address high
// - supervisor compare at csr 0x14d, upper half at 0x15d
// - supervisor pending set when time >= compare, unsigned
// - pending holds until compare exceeds time; update may lag
// - comparator only drives pending; trap logic decides taking it
// - without compare, machine pending bit is machine-writable
// - with compare, machine pending bit read-only, mirrors comparator
// - supervisor pending bit read-only, from environment or comparator
// - timer permit clear: sub-machine compare access is illegal
// - permit set: supervisor access; guest access redirected to guest compare
// - guest compare 64 bits; 32-bit base splits low and upper halves
// - guest compare at csr 0x24d, upper half at 0x25d
// - guest pending when time plus offset, mod 2^64, >= guest compare
// - guest pending holds until compare exceeds time plus offset
// - guest interrupt taken by normal logic only with virtualization on
// - guest pending is read-only OR of injected bit and comparator
// - guest pending stays defined with virtualization off or on
// - guest access with hypervisor permit clear, machine set: virtual fault
// - feature enable at env config bit 63 (upper bit 31), warl
// - machine enable zero: sub-machine access illegal, hypervisor enable reads zero
// - machine enable zero: pending bits act as if feature absent
// - hypervisor enable zero: virtual access faults, guest pending reverts
`timescale 1ns/1ps
module supervisor_timer_compare
    import stc_pkg::*;
#(
    parameter int XLEN = 32,
    parameter bit HAS_COMPARE = 1'b1,
    parameter bit HAS_GUEST = 1'b1
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // csr access path
    input wire logic csr_req_i,
    input wire logic csr_we_i,
    input wire logic [11:0] csr_addr_i,
    input wire logic [XLEN-1:0] csr_wdata_i,
    input wire logic [1:0] priv_i,
    input wire logic virt_i,
    output logic csr_hit_o,
    output logic [XLEN-1:0] csr_rdata_o,
    output logic illegal_o,
    output logic virtual_o,
    // gating configuration
    input wire logic m_timer_access_permit_bit_i,
    input wire logic h_timer_access_permit_bit_i,
    input wire logic m_compare_feature_enable_i,
    input wire logic h_compare_feature_enable_i,
    // time source and guest offset
    input wire logic [63:0] time_i,
    input wire logic [63:0] guest_offset_i,
    // legacy pending sources when the feature is off; the injected guest bit is used in both cases
    input wire logic mpending_we_i,
    input wire logic mpending_wdata_i,
    input wire logic env_sup_timer_pending_i,
    input wire logic inject_guest_timer_pending_i,
    // pending, effective hypervisor enable and compare copies
    output logic sup_timer_pending_o,
    output logic guest_timer_pending_o,
    output logic h_compare_feature_enable_o,
    output logic [63:0] sup_cmp_o,
    output logic [63:0] guest_cmp_o
);
    initial begin
        if (XLEN != 32 && XLEN != 64) begin
            $error("supervisor_timer_compare: XLEN must be 32 or 64");
        end
    end

    localparam bit IS32 = (XLEN == 32);

    logic [63:0] sup_cmp_q;
    logic [63:0] guest_cmp_q;
    logic [63:0] guest_time_q;
    logic sup_reached;
    logic guest_reached;
    logic legacy_stp_q;
    logic [1:0] sel;
    logic upper;
    logic guest_sel;
    access_t verdict;
    logic wr_ok;
    logic [63:0] rd_src;

    // decode an address into target (1 sup, 2 guest, 0 none) and half
    function automatic logic [2:0] decode(input logic [11:0] a);
        logic [2:0] r;
        r = 3'h0;
        if (a == CSR_SUP_CMP) begin
            r = 3'h1;
        end else if (IS32 && a == CSR_SUP_CMP_UPPER) begin
            r = 3'h5;
        end
        if (HAS_GUEST && a == CSR_GUEST_CMP) begin
            r = 3'h2;
        end else if (HAS_GUEST && IS32 && a == CSR_GUEST_CMP_UPPER) begin
            r = 3'h6;
        end
        return r;
    endfunction : decode

    // classify one access
    always_comb begin
        logic [2:0] d;
        d = decode(csr_addr_i);
        sel = d[1:0];
        upper = d[2];
        guest_sel = 1'b0;
        verdict = ACC_NONE;
        if (HAS_COMPARE && sel != 2'h0) begin
            verdict = ACC_OK;
            if (priv_i != PRIV_M) begin
                if (!m_timer_access_permit_bit_i ||
                    !m_compare_feature_enable_i) begin
                    verdict = ACC_ILLEGAL;
                // user level never reaches the compares, guest or not
                end else if (priv_i == PRIV_U) begin
                    verdict = ACC_ILLEGAL;
                end else if (virt_i) begin
                    // guest csr numbers are not reachable from guest
                    if (sel == 2'h2) begin
                        verdict = ACC_VIRTUAL;
                    end else if (!h_timer_access_permit_bit_i ||
                                 !h_compare_feature_enable_i ||
                                 !HAS_GUEST) begin
                        verdict = ACC_VIRTUAL;
                    end else begin
                        guest_sel = 1'b1;
                    end
                end
            end
            if (sel == 2'h2) begin
                guest_sel = 1'b1;
            end
        end
    end

    assign wr_ok = csr_req_i && csr_we_i && verdict == ACC_OK;

    // merge write data into the addressed half
    function automatic logic [63:0] merge(input logic [63:0] old,
                                          input logic [XLEN-1:0] wd,
                                          input logic up);
        logic [63:0] r;
        r = old;
        if (!IS32) begin
            r = 64'(wd);
        end else if (up) begin
            r[63:32] = wd[31:0];
        end else begin
            r[31:0] = wd[31:0];
        end
        return r;
    endfunction : merge

    // supervisor compare register
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            sup_cmp_q <= CMP_RESET;
        end else if (wr_ok && !guest_sel) begin
            sup_cmp_q <= merge(sup_cmp_q, csr_wdata_i, upper);
        end
    end

    // guest compare register
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            guest_cmp_q <= CMP_RESET;
        end else if (wr_ok && guest_sel) begin
            guest_cmp_q <= merge(guest_cmp_q, csr_wdata_i, upper);
        end
    end

    // offset time, truncated to 64 bits
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            guest_time_q <= '0;
        end else begin
            guest_time_q <= time_i + guest_offset_i;
        end
    end

    stc_compare #(
        .WIDTH(64)
    ) u_sup_cmp (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .value_i(time_i),
        .limit_i(sup_cmp_q),
        .reached_o(sup_reached)
    );

    stc_compare #(
        .WIDTH(64)
    ) u_guest_cmp (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .value_i(guest_time_q),
        .limit_i(guest_cmp_q),
        .reached_o(guest_reached)
    );

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            legacy_stp_q <= 1'b0;
        end else if (mpending_we_i) begin
            legacy_stp_q <= mpending_wdata_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            sup_timer_pending_o <= 1'b0;
        end else if (HAS_COMPARE && m_compare_feature_enable_i) begin
            sup_timer_pending_o <= sup_reached;
        end else begin
            sup_timer_pending_o <= legacy_stp_q | env_sup_timer_pending_i;
        end
    end

    // guest pending, defined regardless of virt
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            guest_timer_pending_o <= 1'b0;
        end else if (HAS_COMPARE && HAS_GUEST &&
                     m_compare_feature_enable_i &&
                     h_compare_feature_enable_i) begin
            guest_timer_pending_o <= inject_guest_timer_pending_i |
                                     guest_reached;
        end else begin
            guest_timer_pending_o <= inject_guest_timer_pending_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            h_compare_feature_enable_o <= 1'b0;
        end else begin
            h_compare_feature_enable_o <= HAS_COMPARE && HAS_GUEST &&
                m_compare_feature_enable_i && h_compare_feature_enable_i;
        end
    end

    // read source follows the redirect decision
    assign rd_src = guest_sel ? guest_cmp_q : sup_cmp_q;

    // csr answer one cycle after the request
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            csr_hit_o <= 1'b0;
            csr_rdata_o <= '0;
            illegal_o <= 1'b0;
            virtual_o <= 1'b0;
        end else begin
            csr_hit_o <= csr_req_i && verdict == ACC_OK;
            illegal_o <= csr_req_i && verdict == ACC_ILLEGAL;
            virtual_o <= csr_req_i && verdict == ACC_VIRTUAL;
            if (csr_req_i && verdict == ACC_OK) begin
                csr_rdata_o <= (IS32 && upper) ? XLEN'(rd_src[63:32]) :
                               XLEN'(rd_src);
            end else begin
                csr_rdata_o <= '0;
            end
        end
    end

    // registered copies of compare values
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            sup_cmp_o <= CMP_RESET;
            guest_cmp_o <= CMP_RESET;
        end else begin
            sup_cmp_o <= sup_cmp_q;
            guest_cmp_o <= guest_cmp_q;
        end
    end
endmodule : supervisor_timer_compare

// ==== time_source.sv ====
// platform time source model: counts, loads and holds
`timescale 1ns/1ps
module time_source (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // control from the bench
    input wire logic hold_i,
    input wire logic load_i,
    input wire logic [63:0] load_value_i,
    // shared time value
    output logic [63:0] time_o
);
    // time ticks once a cycle unless held; a load wins over both
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            time_o <= 64'h0;
        end else if (load_i) begin
            time_o <= load_value_i;
        end else if (!hold_i) begin
            time_o <= time_o + 64'h1;
        end
    end
endmodule : time_source

// ==== stc_asserts.sv ====
// port assertions for the timer compare block
`timescale 1ns/1ps
module stc_asserts
    import stc_pkg::*;
#(
    parameter int XLEN = 32
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // csr access
    input wire logic csr_req_i,
    input wire logic [11:0] csr_addr_i,
    input wire logic [1:0] priv_i,
    input wire logic virt_i,
    input wire logic csr_hit_o,
    input wire logic illegal_o,
    input wire logic virtual_o,
    // gating, time and pending
    input wire logic m_timer_access_permit_bit_i,
    input wire logic h_timer_access_permit_bit_i,
    input wire logic m_compare_feature_enable_i,
    input wire logic h_compare_feature_enable_i,
    input wire logic h_compare_feature_enable_o,
    input wire logic [63:0] time_i,
    input wire logic [63:0] guest_offset_i,
    input wire logic sup_timer_pending_o,
    input wire logic guest_timer_pending_o,
    input wire logic [63:0] sup_cmp_o,
    input wire logic [63:0] guest_cmp_o
);
    logic ours;
    logic req;
    logic [63:0] gsum;
    // decode of our numbers; guest time wraps at 64 bits
    assign ours = csr_addr_i inside {CSR_SUP_CMP, CSR_SUP_CMP_UPPER,
        CSR_GUEST_CMP, CSR_GUEST_CMP_UPPER};
    assign req = csr_req_i && ours;
    assign gsum = time_i + guest_offset_i;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // access verdicts and pending levels
    a_hit_cause:
        assert property (csr_hit_o |-> $past(req))
        else $error("hit without request");
    a_user_illegal:
        assert property (req && priv_i == PRIV_U |=> illegal_o && !csr_hit_o)
        else $error("user access not illegal");
    a_permit_illegal:
        assert property (req && priv_i != PRIV_M
            && !m_timer_access_permit_bit_i |=> illegal_o)
        else $error("permit clear not illegal");
    a_enable_illegal:
        assert property (req && priv_i != PRIV_M
            && !m_compare_feature_enable_i |=> illegal_o)
        else $error("enable clear not illegal");
    a_guest_virtual:
        assert property (req && priv_i == PRIV_S && virt_i
            && m_timer_access_permit_bit_i && m_compare_feature_enable_i
            && !(h_timer_access_permit_bit_i && h_compare_feature_enable_i)
            |=> virtual_o && !csr_hit_o)
        else $error("guest access not virtual fault");
    a_mach_ok:
        assert property (req && priv_i == PRIV_M |=> csr_hit_o)
        else $error("machine access refused");
    a_unmapped_quiet:
        assert property (csr_req_i && !ours
            |=> !(csr_hit_o || illegal_o || virtual_o))
        else $error("answer to foreign address");
    a_heff_zero:
        assert property (!m_compare_feature_enable_i
            |=> !h_compare_feature_enable_o)
        else $error("hyp enable not zero");
    a_sup_rise:
        assert property ((m_compare_feature_enable_i
            && time_i >= sup_cmp_o) [*8] |-> sup_timer_pending_o)
        else $error("sup pending missing");
    a_sup_fall:
        assert property ((m_compare_feature_enable_i
            && time_i < sup_cmp_o) [*8] |-> !sup_timer_pending_o)
        else $error("sup pending stuck");
    a_guest_rise:
        assert property ((m_compare_feature_enable_i
            && h_compare_feature_enable_i && gsum >= guest_cmp_o) [*8]
            |-> guest_timer_pending_o)
        else $error("guest pending missing");
endmodule : stc_asserts

bind supervisor_timer_compare stc_asserts #(.XLEN(XLEN)) checker_i (.*);

// ==== supervisor_timer_compare_test.sv ====
// self-checking bench for the timer compare block
`timescale 1ns/1ps
module supervisor_timer_compare_test;
    import stc_pkg::*;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic req = 1'b0, we = 1'b0, virt = 1'b0;
    logic [11:0] addr = 12'h0;
    logic [31:0] wdata = 32'h0;
    logic [1:0] priv = PRIV_S;
    logic mp = 1'b1, hp = 1'b1, me = 1'b1, he = 1'b1;
    logic mwe = 1'b0, mwd = 1'b0, env = 1'b0, inj = 1'b0, load = 1'b0;
    logic [63:0] tval = 64'h0, offs = 64'h0, tnow, scmp, gcmp;
    logic hit, ill, vir, heff, sp, gp;
    logic [31:0] rdata;
    int errors = 0;
    int total_checks = 0;

    // 25 MHz clock
    always #20 clock_i = ~clock_i;

    time_source ts (.clock_i(clock_i), .rst_n_i(rst_n_i), .hold_i(1'b1),
        .load_i(load), .load_value_i(tval), .time_o(tnow));
    supervisor_timer_compare DUT (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .csr_req_i(req), .csr_we_i(we), .csr_addr_i(addr),
        .csr_wdata_i(wdata), .priv_i(priv), .virt_i(virt),
        .csr_hit_o(hit), .csr_rdata_o(rdata), .illegal_o(ill),
        .virtual_o(vir), .m_timer_access_permit_bit_i(mp),
        .h_timer_access_permit_bit_i(hp), .m_compare_feature_enable_i(me),
        .h_compare_feature_enable_i(he), .time_i(tnow),
        .guest_offset_i(offs), .mpending_we_i(mwe), .mpending_wdata_i(mwd),
        .env_sup_timer_pending_i(env), .inject_guest_timer_pending_i(inj),
        .sup_timer_pending_o(sp), .guest_timer_pending_o(gp),
        .h_compare_feature_enable_o(heff), .sup_cmp_o(scmp),
        .guest_cmp_o(gcmp));

    task automatic end_sim;
        if (errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string n, input logic [63:0] e,
            input logic [63:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // one csr access; e is the expected {virtual, illegal, hit} pulses
    task automatic acc(input logic w, input logic [11:0] a,
            input logic [31:0] d, input logic [2:0] e, input logic [31:0] r);
        @(posedge clock_i);
        #1;
        req = 1'b1;
        we = w;
        addr = a;
        wdata = d;
        @(posedge clock_i);
        #1;
        req = 1'b0;
        chk("pulses", {61'h0, e}, {61'h0, vir, ill, hit});
        if (!w) chk("rdata", {32'h0, r}, {32'h0, rdata});
    endtask : acc

    // cfg is {priv, m permit, h permit, m enable, h enable, virt}
    task automatic gate(input logic [6:0] cfg, input logic [11:0] a,
            input logic [2:0] e);
        {priv, mp, hp, me, he, virt} = cfg;
        acc(1'b1, a, 32'h0, e, 32'h0);
    endtask : gate

    task automatic set_time(input logic [63:0] v);
        tval = v;
        load = 1'b1;
        @(posedge clock_i);
        #1;
        load = 1'b0;
    endtask : set_time

    task automatic mwrite(input logic v);
        mwe = 1'b1;
        mwd = v;
        @(posedge clock_i);
        #1;
        mwe = 1'b0;
    endtask : mwrite

    // bounded wait for both pending levels; a miss ends the run
    task automatic wait_pend(input logic s, input logic g);
        for (int i = 0; i < 12 && {sp, gp} !== {s, g}; i++) begin
            @(posedge clock_i);
            #1;
        end
        chk("pending", {62'h0, s, g}, {62'h0, sp, gp});
        if ({sp, gp} !== {s, g}) end_sim();
    endtask : wait_pend

    initial begin
        repeat (6) @(posedge clock_i);
        #1;
        rst_n_i = 1'b1;
        chk("sup_cmp", CMP_RESET, scmp);
        chk("guest_cmp", CMP_RESET, gcmp);
        set_time(64'h0000_0001_0000_0000);
        acc(1'b1, CSR_SUP_CMP, 32'h0, 3'b001, 32'h0);
        acc(1'b1, CSR_SUP_CMP_UPPER, 32'h1, 3'b001, 32'h0);
        acc(1'b0, CSR_SUP_CMP, 32'h0, 3'b001, 32'h0);
        acc(1'b0, CSR_SUP_CMP_UPPER, 32'h0, 3'b001, 32'h1);
        chk("sup_cmp", 64'h0000_0001_0000_0000, scmp);
        wait_pend(1'b1, 1'b0);
        acc(1'b1, CSR_SUP_CMP, 32'h1, 3'b001, 32'h0);
        wait_pend(1'b0, 1'b0);
        set_time(64'h8000_0000_0000_0000);
        offs = 64'h8000_0000_0000_0001;
        acc(1'b1, CSR_SUP_CMP_UPPER, 32'h7fff_ffff, 3'b001, 32'h0);
        acc(1'b1, CSR_GUEST_CMP, 32'h2, 3'b001, 32'h0);
        acc(1'b1, CSR_GUEST_CMP_UPPER, 32'h0, 3'b001, 32'h0);
        wait_pend(1'b1, 1'b0);
        acc(1'b1, CSR_GUEST_CMP, 32'h1, 3'b001, 32'h0);
        wait_pend(1'b1, 1'b1);
        virt = 1'b1;
        acc(1'b1, CSR_SUP_CMP, 32'h5, 3'b001, 32'h0);
        acc(1'b0, CSR_SUP_CMP, 32'h0, 3'b001, 32'h5);
        wait_pend(1'b1, 1'b0);
        chk("guest_cmp", 64'h5, gcmp);
        inj = 1'b1;
        wait_pend(1'b1, 1'b1);
        inj = 1'b0;
        gate({PRIV_U, 5'b11110}, CSR_SUP_CMP, 3'b010);
        gate({PRIV_S, 5'b01110}, CSR_SUP_CMP, 3'b010);
        gate({PRIV_S, 5'b11010}, CSR_GUEST_CMP, 3'b010);
        chk("h_enable", 64'h0, {63'h0, heff});
        gate({PRIV_S, 5'b10111}, CSR_SUP_CMP, 3'b100);
        gate({PRIV_S, 5'b11101}, CSR_SUP_CMP_UPPER, 3'b100);
        gate({PRIV_S, 5'b01111}, CSR_SUP_CMP, 3'b010);
        gate({PRIV_S, 5'b11111}, 12'h14e, 3'b000);
        chk("sup_cmp", 64'h7fff_ffff_0000_0001, scmp);
        chk("guest_cmp", 64'h5, gcmp);
        gate({PRIV_M, 5'b00000}, CSR_SUP_CMP, 3'b001);
        {priv, mp, hp, me, he, virt} = {PRIV_S, 5'b11110};
        mwrite(1'b0);
        repeat (6) @(posedge clock_i);
        #1;
        chk("sup_pending", 64'h1, {63'h0, sp});
        chk("h_enable", 64'h1, {63'h0, heff});
        offs = 64'h8000_0000_0000_0010;
        wait_pend(1'b1, 1'b1);
        he = 1'b0;
        wait_pend(1'b1, 1'b0);
        me = 1'b0;
        wait_pend(1'b0, 1'b0);
        env = 1'b1;
        wait_pend(1'b1, 1'b0);
        env = 1'b0;
        mwrite(1'b1);
        wait_pend(1'b1, 1'b0);
        mwrite(1'b0);
        wait_pend(1'b0, 1'b0);
        end_sim();
    end
endmodule : supervisor_timer_compare_test
